// ==== svr_host_model.sv ====
// Purpose: Host side model driving the serial command port
// Assumes: Mode 0 framing, two system clocks per serial clock phase
// Notes: Tasks are called from the bench at a falling clock edge
`timescale 1ns/1ps
module svr_host_model (
  // Clock
  input wire logic i_clk,
  // Serial pins
  output logic o_spi_cs_n,
  output logic o_spi_sclk,
  output logic o_spi_mosi,
  input wire logic i_spi_miso,
  // Frame settled strobe
  output logic o_done
);
  logic [7:0] rd;
  // Idle levels from time zero
  initial begin
    o_spi_cs_n = 1'b1;
    o_spi_sclk = 1'b0;
    o_spi_mosi = 1'b0;
    o_done = 1'b0;
    rd = 8'h00;
  end
  // One bit: data set while clock low, readback taken at the rise
  task automatic bit_out(input logic b);
    o_spi_mosi = b;
    repeat (2) @(negedge i_clk);
    o_spi_sclk = 1'b1;
    rd = {rd[6:0], i_spi_miso};
    repeat (2) @(negedge i_clk);
    o_spi_sclk = 1'b0;
  endtask
  task automatic frame(input logic [7:0] op, input logic [15:0] d, input int nd);
    o_spi_cs_n = 1'b0;
    for (int i = 7; i >= 0; i--) bit_out(op[i]);
    for (int i = 15; i > 15 - nd; i--) bit_out(d[i]);
    // Last fall must be seen before release, or byte writes are lost
    repeat (2) @(negedge i_clk);
    o_spi_cs_n = 1'b1;
    o_spi_mosi = ~o_spi_mosi;
    @(negedge i_clk);
    o_done <= 1'b1;
    @(negedge i_clk);
    o_done <= 1'b0;
    repeat (2) @(negedge i_clk);
  endtask
endmodule // svr_host_model

// ==== svr_pkg.sv ====
// Purpose: Shared constants for the serial video register command block
// Assumes: Serial mode 0, commands framed by an active-low select
// Notes: Four video/register blocks share one serial command port
package svr_pkg;
  // Block count and register widths
  localparam int NUM_BLOCKS = 4;
  localparam int OPC_W = 8;
  localparam int WORD_W = 16;
  localparam int POS_W = 12;
  localparam int MASK_W = 4;
  localparam int CNT_W = 5;
  localparam int BYTE_BITS = 8;
  localparam int WORD_BITS = 16;
  // Command opcodes
  localparam logic [7:0] OP_MASK_READ = 8'hB7;
  localparam logic [7:0] OP_MASK_WRITE = 8'hB8;
  localparam logic [7:0] OP_AREA_BEGIN = 8'h28;
  localparam logic [7:0] OP_AREA_FINISH = 8'h29;
  localparam logic [7:0] OP_LINE_SPAN = 8'h2A;
  localparam logic [7:0] OP_CTRL_ONE = 8'h2B;
  // Field positions of the line span register
  localparam int SPAN_PINS_BIT = 15;
  // Field positions of control word one
  localparam int C1_RAW_BIT = 15;
  localparam int C1_TABLE_BIT = 14;
  localparam int C1_CLKSRC_BIT = 13;
  localparam int C1_PWR_BIT = 12;
  localparam int C1_DIV_HI = 11;
  localparam int C1_DIV_LO = 3;
  localparam int C1_SKIP_HI = 2;
  localparam int C1_SKIP_LO = 0;
  // Reset values
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [3:0] MASK_RSVD = 4'h0;
  // Timing: sync interval in video clocks, video clocks per subcarrier
  localparam int SYNC_VIDEO_CLOCK = 10;
  localparam int VIDEO_CLOCK_PER_SUBCARRIER = 8;
  localparam logic [2:0] DIV_LOW_ONES = 3'h7;
  // Command sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_OPCODE = 4'h1,
    ST_DATA = 4'h2,
    ST_READOUT = 4'h4,
    ST_IGNORE = 4'h8
  } svr_state_e;
endpackage

// ==== svr_spi_video_regs.sv ====
// Purpose: Serial command interpreter for block mask and video timing registers
// Assumes: Serial pins synchronous to i_clk, i_clk far faster than serial clock
// Notes: Registers are write-only except the block mask readback
// Behaviour
// R1: B7h read shifts mask out, tri-state after
// R2: Mask write loads all four block copies
// R3: Low four bits mask block access, reset zero
// R4: Mask applies to register commands only
// R5: B8h write updates after final clock low
// R6: Video write updates every unmasked block
// R7: Host should read one block at once
// R8: 28h begin write keeps 11:0 on release
// R9: Begin adds ten video clock sync interval
// R10: Host keeps begin under span/8, min 7
// R11: 29h finish write keeps 11:0 on release
// R12: Host keeps finish in range above begin
// R13: 2Ah span write keeps 11:0 on release
// R14: Span bit 15 routes nibble to pins
// R15: Raw buffer length is span plus one
// R16: 2Bh control word one updates on release
// R17: Bit 15 enables raw converter mode
// R18: Bit 14 selects chroma table source
// R19: Bit 13 selects video clock source
// R20: Bit 12 powers multiplier, restarts lock check
// R21: Divider is field with 111 plus one
// R22: Bits 2-0 set chroma fetch skip runs
// R23: Enabled blocks latch together on release
// R24: Mask reserved bits read zero, writes ignored
`timescale 1ns/1ps
module svr_spi_video_regs #(
  parameter int NUM_BLOCKS = svr_pkg::NUM_BLOCKS
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Serial command pins
  input wire logic i_spi_cs_n,
  input wire logic i_spi_sclk,
  input wire logic i_spi_mosi,
  output logic o_spi_miso,
  output logic o_spi_miso_oe,
  // Per-block timing values, block n in slice n
  output logic [NUM_BLOCKS*12-1:0] o_active_area_begin,
  output logic [NUM_BLOCKS*12-1:0] o_active_area_finish,
  output logic [NUM_BLOCKS*12-1:0] o_scan_line_span,
  output logic [NUM_BLOCKS*16-1:0] o_begin_video_clocks,
  output logic [NUM_BLOCKS*13-1:0] o_dac_buffer_length,
  // Per-block control outputs
  output logic [NUM_BLOCKS-1:0] o_ctrl_nibble_to_pins,
  output logic [NUM_BLOCKS-1:0] o_raw_converter_mode,
  output logic [NUM_BLOCKS-1:0] o_chroma_table_select,
  output logic [NUM_BLOCKS-1:0] o_video_clock_source,
  output logic [NUM_BLOCKS-1:0] o_multiplier_power_on,
  output logic [NUM_BLOCKS-1:0] o_lock_check_restart,
  output logic [NUM_BLOCKS*13-1:0] o_converter_clock_divider,
  output logic [NUM_BLOCKS*3-1:0] o_chroma_fetch_skip,
  output logic [NUM_BLOCKS*4-1:0] o_block_access_mask
);

  // Opcodes that address the per-block video registers
  function automatic logic is_video_op(input logic [7:0] op);
    is_video_op = (op == svr_pkg::OP_AREA_BEGIN) || (op == svr_pkg::OP_AREA_FINISH) ||
                  (op == svr_pkg::OP_LINE_SPAN) || (op == svr_pkg::OP_CTRL_ONE);
  endfunction

  svr_pkg::svr_state_e state, next_state;
  logic [svr_pkg::CNT_W-1:0] bit_cnt, next_bit_cnt;
  logic [7:0] opcode, next_opcode;
  logic [15:0] shreg, next_shreg;
  logic [7:0] out_sh, next_out_sh;
  logic miso, next_miso;
  logic sclk_q, next_sclk_q;
  logic cs_q, next_cs_q;
  logic mask_done, next_mask_done;
  logic sclk_rise, sclk_fall, cs_release;
  logic mask_commit, video_commit;

  // Edge detection on pins already synchronous to i_clk
  assign sclk_rise = i_spi_sclk && !sclk_q && !i_spi_cs_n;
  assign sclk_fall = !i_spi_sclk && sclk_q && !i_spi_cs_n;
  assign cs_release = i_spi_cs_n && !cs_q;

  // R5: commit on low clock after bit eight
  assign mask_commit = sclk_fall && (state == svr_pkg::ST_DATA) && !mask_done &&
                       (opcode == svr_pkg::OP_MASK_WRITE) &&
                       (bit_cnt == svr_pkg::CNT_W'(svr_pkg::BYTE_BITS));
  // R23: one release event commits every enabled block
  assign video_commit = cs_release && (state == svr_pkg::ST_DATA) && is_video_op(opcode) &&
                        (bit_cnt == svr_pkg::CNT_W'(svr_pkg::WORD_BITS));

  // Command sequencer next state
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_opcode = opcode;
    next_shreg = shreg;
    next_out_sh = out_sh;
    next_miso = miso;
    next_sclk_q = i_spi_sclk;
    next_cs_q = i_spi_cs_n;
    next_mask_done = mask_done || mask_commit;
    if (i_spi_cs_n) begin
      next_state = svr_pkg::ST_OPCODE;
      next_bit_cnt = '0;
      next_mask_done = 1'b0;
      next_miso = 1'b0;
    end else if (sclk_rise) begin
      case (state)
        svr_pkg::ST_OPCODE: begin
          next_shreg = {shreg[14:0], i_spi_mosi};
          next_bit_cnt = bit_cnt + 1'b1;
          if (bit_cnt == svr_pkg::CNT_W'(svr_pkg::BYTE_BITS - 1)) begin
            next_opcode = {shreg[6:0], i_spi_mosi};
            next_bit_cnt = '0;
            next_shreg = svr_pkg::WORD_RESET;
            // R1: mask byte staged for readout
            if (next_opcode == svr_pkg::OP_MASK_READ) begin
              next_state = svr_pkg::ST_READOUT;
              // R24: reserved bits read zero
              next_out_sh = {svr_pkg::MASK_RSVD, o_block_access_mask[3:0]};
            end else if (next_opcode == svr_pkg::OP_MASK_WRITE || is_video_op(next_opcode)) begin
              next_state = svr_pkg::ST_DATA;
            end else begin
              next_state = svr_pkg::ST_IGNORE;
            end
          end
        end
        svr_pkg::ST_DATA: begin
          // Extra bits beyond the word are ignored, first word wins
          if ((opcode == svr_pkg::OP_MASK_WRITE) ?
              (bit_cnt < svr_pkg::CNT_W'(svr_pkg::BYTE_BITS)) :
              (bit_cnt < svr_pkg::CNT_W'(svr_pkg::WORD_BITS))) begin
            next_shreg = {shreg[14:0], i_spi_mosi};
            next_bit_cnt = bit_cnt + 1'b1;
          end
        end
        svr_pkg::ST_READOUT, svr_pkg::ST_IGNORE: begin
          next_state = state;
        end
        default: next_state = svr_pkg::ST_OPCODE;
      endcase
    end else if (sclk_fall && state == svr_pkg::ST_READOUT) begin
      // R1: MSB first on falling edges, repeats while selected
      next_miso = out_sh[7];
      next_out_sh = {out_sh[6:0], out_sh[7]};
    end
  end

  // Command sequencer registers
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= svr_pkg::ST_OPCODE;
      bit_cnt <= '0;
      opcode <= 8'h00;
      shreg <= svr_pkg::WORD_RESET;
      out_sh <= 8'h00;
      miso <= 1'b0;
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
      mask_done <= 1'b0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      opcode <= next_opcode;
      shreg <= next_shreg;
      out_sh <= next_out_sh;
      miso <= next_miso;
      sclk_q <= next_sclk_q;
      cs_q <= next_cs_q;
      mask_done <= next_mask_done;
    end
  end

  // R1: drive only during readout, released with select
  assign o_spi_miso = miso;
  assign o_spi_miso_oe = (state == svr_pkg::ST_READOUT) && !i_spi_cs_n;

  // Per-block register copies
  genvar b;
  generate
    for (b = 0; b < NUM_BLOCKS; b++) begin : g_blk
      logic [3:0] mask, next_mask;
      logic [15:0] begin_r, finish_r, span_r, ctrl_r;
      logic [15:0] next_begin, next_finish, next_span, next_ctrl;
      logic restart, next_restart;
      logic enabled;

      // R3: own mask bit gates this block
      // R4: only video register commands are gated
      assign enabled = !mask[b];

      // Register copy next values
      always_comb begin
        next_mask = mask;
        next_begin = begin_r;
        next_finish = finish_r;
        next_span = span_r;
        next_ctrl = ctrl_r;
        next_restart = 1'b0;
        // R2: every copy loaded, mask ignored
        if (mask_commit) begin
          next_mask = shreg[3:0];
        end
        // R6: write lands in every unmasked block
        if (video_commit && enabled) begin
          case (opcode)
            // R8: begin keeps low twelve bits
            svr_pkg::OP_AREA_BEGIN: next_begin = {4'h0, shreg[11:0]};
            // R11: finish keeps low twelve bits
            svr_pkg::OP_AREA_FINISH: next_finish = {4'h0, shreg[11:0]};
            // R13: span keeps 11:0 plus pin routing bit
            svr_pkg::OP_LINE_SPAN: next_span = {shreg[15], 3'h0, shreg[11:0]};
            svr_pkg::OP_CTRL_ONE: begin
              // R16: whole control word loaded
              next_ctrl = shreg;
              // R20: a high power bit restarts lock check
              next_restart = shreg[svr_pkg::C1_PWR_BIT];
            end
            default: next_ctrl = ctrl_r;
          endcase
        end
      end

      // Register copies, all zero at power-up
      always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          mask <= svr_pkg::MASK_RESET;
          begin_r <= svr_pkg::WORD_RESET;
          finish_r <= svr_pkg::WORD_RESET;
          span_r <= svr_pkg::WORD_RESET;
          ctrl_r <= svr_pkg::WORD_RESET;
          restart <= 1'b0;
        end else begin
          mask <= next_mask;
          begin_r <= next_begin;
          finish_r <= next_finish;
          span_r <= next_span;
          ctrl_r <= next_ctrl;
          restart <= next_restart;
        end
      end

      // Field outputs of this block
      assign o_block_access_mask[b*4 +: 4] = mask;
      assign o_active_area_begin[b*12 +: 12] = begin_r[11:0];
      assign o_active_area_finish[b*12 +: 12] = finish_r[11:0];
      assign o_scan_line_span[b*12 +: 12] = span_r[11:0];
      // R9: begin in video clocks includes fixed sync
      assign o_begin_video_clocks[b*16 +: 16] = 16'(begin_r[11:0] * svr_pkg::VIDEO_CLOCK_PER_SUBCARRIER
                                                 + svr_pkg::SYNC_VIDEO_CLOCK);
      // R15: raw buffer holds span plus one entries
      assign o_dac_buffer_length[b*13 +: 13] = 13'(span_r[11:0]) + 13'h0001;
      // R14: nibble routing to pins
      assign o_ctrl_nibble_to_pins[b] = span_r[svr_pkg::SPAN_PINS_BIT];
      // R17: raw converter mode
      assign o_raw_converter_mode[b] = ctrl_r[svr_pkg::C1_RAW_BIT];
      // R18: chroma from translate tables
      assign o_chroma_table_select[b] = ctrl_r[svr_pkg::C1_TABLE_BIT];
      // R19: clock from multiplier when set
      assign o_video_clock_source[b] = ctrl_r[svr_pkg::C1_CLKSRC_BIT];
      // R20: multiplier and crystal power
      assign o_multiplier_power_on[b] = ctrl_r[svr_pkg::C1_PWR_BIT];
      assign o_lock_check_restart[b] = restart;
      // R21: field with three ones appended, plus one
      assign o_converter_clock_divider[b*13 +: 13] =
        13'({ctrl_r[svr_pkg::C1_DIV_HI:svr_pkg::C1_DIV_LO], svr_pkg::DIV_LOW_ONES}) + 13'h0001;
      // R22: zero disables chroma fetch skip
      assign o_chroma_fetch_skip[b*3 +: 3] = ctrl_r[svr_pkg::C1_SKIP_HI:svr_pkg::C1_SKIP_LO];
    end
  endgenerate

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_mask_write_done;
    mask_commit ##1 1'b1;
  endsequence

  a_mask_all_copies: assert property (s_mask_write_done |-> // R2
    o_block_access_mask == {NUM_BLOCKS{$past(shreg[3:0])}})
    else $error("mask copies differ after write");
  a_mask_write_time: assert property (mask_commit |-> $past(sclk_q) && !i_spi_sclk) // R5
    else $error("mask write not on clock low");
  a_miso_release: assert property (i_spi_cs_n |-> !o_spi_miso_oe) // R1
    else $error("output driven while deselected");
  a_readout_drive: assert property ((state == svr_pkg::ST_READOUT) && !i_spi_cs_n // R1
    |-> o_spi_miso_oe) else $error("readout not driven");
  a_masked_block_hold: assert property (video_commit && g_blk[0].mask[0] // R3
    |=> $stable(g_blk[0].ctrl_r) && $stable(g_blk[0].begin_r))
    else $error("masked block updated");
  a_unmasked_update: assert property (video_commit && !g_blk[1].mask[1] && // R6
    opcode == svr_pkg::OP_CTRL_ONE |=> g_blk[1].ctrl_r == $past(shreg))
    else $error("enabled block missed write");
  a_begin_low_bits: assert property (video_commit && !g_blk[0].mask[0] && // R8
    opcode == svr_pkg::OP_AREA_BEGIN |=> o_active_area_begin[11:0] == $past(shreg[11:0]))
    else $error("begin not loaded");
  a_update_only_release: assert property (!cs_release |=> $stable(g_blk[2].span_r)) // R13
    else $error("span changed without release");
  a_restart_pulse: assert property (o_lock_check_restart[0] |=> !o_lock_check_restart[0]) // R20
    else $error("restart not a pulse");
  a_mask_rsvd_zero: assert property ((state == svr_pkg::ST_READOUT) && // R24
    ($past(state) == svr_pkg::ST_OPCODE) |-> (out_sh[7:4] == svr_pkg::MASK_RSVD) &&
    (opcode == svr_pkg::OP_MASK_READ))
    else $error("readout reserved bits not zero");
endmodule // svr_spi_video_regs

// ==== tb.sv ====
// Purpose: Self-checking bench for the serial video register block
// Assumes: Host model drives the pins on the falling clock edge
// Notes: Expectations come from a shadow copy of every block's registers
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fails++; \
  $display("[FAIL] %0t got %h want %h", $time, a, e); end end
module tb;
  typedef struct {int sel; logic [63:0] v;} svr_note_s;
  logic i_clk, i_reset_n, cs_n, sclk, mosi, miso, miso_oe, done;
  logic [47:0] ab, af, sp;
  logic [63:0] bv;
  logic [51:0] bl, dv;
  logic [3:0] pins, raw, tbl, csrc, pwr, rst, mask, rs;
  logic [3:0] rst_seen;
  logic [11:0] skip;
  logic [15:0] msk;
  logic [15:0] sh [4][4];
  svr_note_s notes[$];
  int fails, n_compared;
  svr_spi_video_regs dut_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_spi_cs_n(cs_n),
    .i_spi_sclk(sclk), .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe(miso_oe),
    .o_active_area_begin(ab), .o_active_area_finish(af), .o_scan_line_span(sp),
    .o_begin_video_clocks(bv), .o_dac_buffer_length(bl), .o_ctrl_nibble_to_pins(pins),
    .o_raw_converter_mode(raw), .o_chroma_table_select(tbl), .o_video_clock_source(csrc),
    .o_multiplier_power_on(pwr), .o_lock_check_restart(rst),
    .o_converter_clock_divider(dv), .o_chroma_fetch_skip(skip), .o_block_access_mask(msk));
  svr_host_model host_u (.i_clk(i_clk), .o_spi_cs_n(cs_n), .o_spi_sclk(sclk),
    .o_spi_mosi(mosi), .i_spi_miso(miso), .o_done(done));
  // Observed value for each note selector
  function automatic logic [63:0] act(int s);
    case (s)
      0: return {16'h0, ab};
      1: return {16'h0, af};
      2: return {16'h0, sp};
      3: return bv;
      4: return {12'h0, bl};
      5: return {60'h0, pins};
      6: return {60'h0, raw};
      7: return {60'h0, tbl};
      8: return {60'h0, csrc};
      9: return {60'h0, pwr};
      10: return {60'h0, rst_seen};
      11: return {12'h0, dv};
      12: return {52'h0, skip};
      13: return {48'h0, msk};
      14: return {63'h0, miso_oe};
      default: return {56'h0, host_u.rd};
    endcase
  endfunction
  // Expected value from the shadow registers
  function automatic logic [63:0] expv(int s);
    logic [63:0] r;
    r = 64'h0;
    for (int b = 0; b < 4; b++) begin
      case (s)
        0, 1, 2: r[b*12+:12] = sh[s][b][11:0];
        3: r[b*16+:16] = {4'h0, sh[0][b][11:0]} * 16'h8 + 16'hA;
        4: r[b*13+:13] = {1'b0, sh[2][b][11:0]} + 13'h1;
        5: r[b] = sh[2][b][15];
        6, 7, 8, 9: r[b] = sh[3][b][21-s];
        10: r[b] = rs[b];
        11: r[b*13+:13] = {1'b0, sh[3][b][11:3], 3'h7} + 13'h1;
        12: r[b*3+:3] = sh[3][b][2:0];
        13: r[b*4+:4] = mask;
        14: r = 64'h0;
        default: r = {60'h0, mask};
      endcase
    end
    return r;
  endfunction
  // Note expectations, then send the frame; short frames change nothing
  task automatic cmd(input logic [7:0] op, input logic [15:0] d, input int nd);
    rs = 4'h0;
    if (op == svr_pkg::OP_MASK_WRITE && nd >= 8)
      mask = d[11:8];
    for (int b = 0; b < 4; b++) begin
      // unmasked blocks take the word together
      if (op[7:2] == 6'hA && nd >= 16 && !mask[b]) begin
        sh[op[1:0]][b] = d;
        rs[b] = (op == svr_pkg::OP_CTRL_ONE) && d[12];
      end
    end
    for (int s = 0; s < 16; s++)
      if (s < 15 || op == svr_pkg::OP_MASK_READ)
        notes.push_back('{s, expv(s)});
    host_u.frame(op, d, nd);
  endtask
  // Restart is a one-cycle pulse, so catch it after release until the next frame
  always @(negedge i_clk) begin
    if (!cs_n || !i_reset_n) begin
      rst_seen <= 4'h0;
    end else begin
      rst_seen <= rst_seen | rst;
    end
  end
  // Compare every pending note once the frame has settled
  always @(negedge i_clk) begin
    if (done === 1'b1) begin
      while (notes.size() > 0) begin
        svr_note_s n;
        n = notes.pop_front();
        `CHK(act(n.sel), n.v)
      end
    end
  end
  // 200 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // Watchdog against a hung frame
  initial begin
    repeat (100000) @(posedge i_clk);
    fails++;
    conclude();
  end
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial begin
    int ln, bg, fn, sd;
    fails = 0;
    n_compared = 0;
    i_reset_n = 1'b0;
    mask = 4'h0;
    rs = 4'h0;
    foreach (sh[i, j]) sh[i][j] = 16'h0;
    sd = $urandom(32'h0F84);
    repeat (12) @(negedge i_clk);
    i_reset_n = 1'b1;
    repeat (2) @(negedge i_clk);
    // host reads back only the shared mask, never mixed block values
    cmd(svr_pkg::OP_MASK_READ, 16'h0, 8);
    $display("test reset done");
    cmd(svr_pkg::OP_MASK_WRITE, 16'hF500, 8);
    cmd(svr_pkg::OP_MASK_READ, 16'h0, 8);
    $display("test mask done");
    for (int k = 0; k < 2; k++) begin
      cmd(svr_pkg::OP_MASK_WRITE, k ? 16'h0A00 : 16'h0000, 8);
      // begin and finish kept inside one eighth of the line
      ln = 512 + $urandom % 3584;
      bg = 7 + $urandom % (ln / 8 - 7);
      fn = bg + 1 + $urandom % (ln / 8 - bg);
      cmd(svr_pkg::OP_LINE_SPAN, {4'($urandom), 12'(ln)}, 16);
      cmd(svr_pkg::OP_AREA_BEGIN, {4'($urandom), 12'(bg)}, 16);
      cmd(svr_pkg::OP_AREA_FINISH, {4'($urandom), 12'(fn)}, 16);
      cmd(svr_pkg::OP_CTRL_ONE, 16'($urandom) | 16'h1000, 16);
      $display("test video writes %0d done", k);
    end
    cmd(svr_pkg::OP_MASK_WRITE, 16'hFF00, 8);
    cmd(svr_pkg::OP_CTRL_ONE, 16'($urandom), 16);
    cmd(svr_pkg::OP_MASK_READ, 16'h0, 8);
    $display("test all blocked done");
    cmd(svr_pkg::OP_MASK_WRITE, 16'h0000, 8);
    cmd(svr_pkg::OP_LINE_SPAN, 16'($urandom), 12);
    cmd(svr_pkg::OP_MASK_WRITE, 16'hF800, 5);
    cmd(svr_pkg::OP_MASK_READ, 16'h0, 8);
    $display("test short frames done");
    conclude();
  end
endmodule // tb
